// File: logic/sdq_pkg.sv
// sdq_pkg: shared constants and types of the sdram control block
package sdq_pkg;
    // array geometry
    localparam int BANK_CNT = 4;
    localparam int BANK_W = 2;
    localparam int ROW_CNT = 8192;
    localparam int ROW_W = 13;
    localparam int ADDR_W = 13;
    localparam int COLS_X4 = 4096;
    localparam int COLS_X8 = 2048;
    localparam int COLS_X16 = 1024;
    localparam int COL_W_X16 = 10;
    localparam int COL_FULL_W = 12;
    localparam int DATA_W_X16 = 16;
    // low column bits backed by storage
    localparam int MEM_CB = 3;
    // address line that carries precharge scope / auto precharge
    localparam int APRE_BIT = 10;
    // mode word fields
    localparam int MODE_BL_LSB = 0;
    localparam int MODE_BL_W = 3;
    localparam int MODE_BT_BIT = 3;
    // burst_count_setting codes
    localparam logic [2:0] BL_1 = 3'h0;
    localparam logic [2:0] BL_2 = 3'h1;
    localparam logic [2:0] BL_4 = 3'h2;
    localparam logic [2:0] BL_8 = 3'h3;
    localparam logic [2:0] BL_FULL = 3'h7;
    // burst masks per length
    localparam int BL_MASK_2 = 1;
    localparam int BL_MASK_4 = 3;
    localparam int BL_MASK_8 = 7;
    // command codes {cs_n, ras_n, cas_n, we_n}
    localparam logic [3:0] CMD_LMR = 4'h0;
    localparam logic [3:0] CMD_REF = 4'h1;
    localparam logic [3:0] CMD_PRE = 4'h2;
    localparam logic [3:0] CMD_ACT = 4'h3;
    localparam logic [3:0] CMD_WR = 4'h4;
    localparam logic [3:0] CMD_RD = 4'h5;
    localparam logic [3:0] CMD_BST = 4'h6;
    // read data and mask latency in clocks
    localparam int DQM_LAT = 2;
    // power states
    typedef enum logic [4:0] {
        PWR_RUN = 5'h01,
        PWR_PDN_PRE = 5'h02,
        PWR_PDN_ACT = 5'h04,
        PWR_SELF = 5'h08,
        PWR_SUSP = 5'h10
    } sdq_pwr_t;
    typedef logic [3:0] sdq_cmd_t;
endpackage : sdq_pkg

// File: logic/sdq_stream_if.sv
// sdq_stream_if: valid/ready word stream between block modules
`timescale 1ns/10ps
`default_nettype none
interface sdq_stream_if #(parameter int W = 16);
    logic [W-1:0] data; // word
    logic valid; // word present
    logic ready; // sink takes word
    modport src (output data, output valid, input ready);
    modport snk (input data, input valid, output ready);
endinterface : sdq_stream_if
`default_nettype wire

// File: logic/sdq_pair_buf.sv
// sdq_pair_buf: two-entry valid/ready buffer
`timescale 1ns/10ps
`default_nettype none
module sdq_pair_buf #(
    parameter int W = 16,
    parameter int DEPTH = 2
) (
    // clock and reset
    input wire logic ref_clk,
    input wire logic resetn,
    // streams
    sdq_stream_if.snk up,
    sdq_stream_if.src dn
);
    localparam int PW = $clog2(DEPTH);
    logic [W-1:0] slot_r [DEPTH]; // storage
    logic [PW-1:0] wp_r; // write index
    logic [PW-1:0] rp_r; // read index
    logic [PW:0] cnt_r; // fill level
    wire logic push;
    wire logic pop;
    // honest full and empty
    assign up.ready = (cnt_r != (PW+1)'(DEPTH));
    assign dn.valid = (cnt_r != '0);
    assign dn.data = slot_r[rp_r];
    assign push = up.valid && up.ready;
    assign pop = dn.valid && dn.ready;
    // entry write
    always_ff @(posedge ref_clk) begin
        if (push) begin
            slot_r[wp_r] <= up.data;
        end
    end
    // pointers and level
    always_ff @(posedge ref_clk or negedge resetn) begin
        if (!resetn) begin
            wp_r <= '0;
            rp_r <= '0;
            cnt_r <= '0;
        end else begin
            wp_r <= push ? PW'((wp_r + 1'b1) % DEPTH) : wp_r;
            rp_r <= pop ? PW'((rp_r + 1'b1) % DEPTH) : rp_r;
            cnt_r <= cnt_r + (PW+1)'(push) - (PW+1)'(pop);
        end
    end
endmodule : sdq_pair_buf
`default_nettype wire

// File: logic/sdq_ctrl.sv
// sdq_ctrl: command, burst, bank and power logic of a quad-bank sdram
// Behaviour
// - all inputs sampled on rising clock edge
// - four banks, 8192 rows, width-dependent columns
// - activate takes bank bits and row
// - read/write address gives starting column
// - burst 1,2,4,8, full page, terminate
// - device generates following columns in sequence
// - auto precharge closes row after burst
// - new column accepted every clock cycle
// - precharge one bank while accessing another
// - clock active only while cke high
// - cke low picks power-down, self refresh, suspend
// - cke watched until power state exits
// - inputs disabled in power-down, self refresh
// - chip select high masks every command
// - chip select part of command code
// - each edge with clock active advances burst and output
// - auto refresh and power-down provided
// - command from strobes plus chip select
// - mask drops writes, floats reads after two
// - precharge line high closes all banks
// - line ten on read/write is auto precharge
`timescale 1ns/10ps
`default_nettype none
module sdq_ctrl #(
    parameter int DATA_W = sdq_pkg::DATA_W_X16,
    parameter int COL_W = sdq_pkg::COL_W_X16,
    parameter int MEM_CB = sdq_pkg::MEM_CB
) (
    // clock and reset
    input wire logic ref_clk,
    input wire logic resetn,
    // command pins
    input wire logic cke,
    input wire logic cs_n,
    input wire logic ras_n,
    input wire logic cas_n,
    input wire logic we_n,
    input wire logic [sdq_pkg::BANK_W-1:0] bank_select_bits,
    input wire logic [sdq_pkg::ADDR_W-1:0] row_column_address_lines,
    // data pins
    input wire logic dqm,
    input wire logic [DATA_W-1:0] dq_in,
    output logic [DATA_W-1:0] dq_out,
    output logic dq_oe_n,
    // status
    output sdq_pkg::sdq_pwr_t pwr_state,
    output logic [sdq_pkg::BANK_CNT-1:0] bank_open,
    output logic burst_busy,
    output logic refresh_pulse,
    output logic in_buf_en
);
    import sdq_pkg::*;

    localparam int MEM_N = BANK_CNT * (2 ** MEM_CB);
    localparam int MI_W = BANK_W + MEM_CB;

    sdq_pwr_t pwr_r; // power state
    sdq_pwr_t pwr_nxt;
    logic [BANK_CNT-1:0] open_r; // row open per bank
    logic [ROW_W-1:0] row_r [BANK_CNT]; // open row per bank
    logic [MODE_BL_W-1:0] bl_code_r; // burst_count_setting
    logic bt_r; // interleaved order when set
    logic burst_r; // burst continuing
    logic burst_wr_r; // burst is a write
    logic burst_apre_r; // close row at burst end
    logic [BANK_W-1:0] bbank_r; // burst bank
    logic [COL_W-1:0] start_r; // burst start column
    logic [COL_W-1:0] cnt_r; // next location index
    logic [DATA_W-1:0] mem_r [MEM_N]; // backing store
    logic [DATA_W-1:0] pipe_r; // read stage one
    logic pipe_vld_r;
    logic dqm_d1_r; // mask delay chain
    logic dqm_d2_r;
    logic [DATA_W-1:0] dq_out_r; // output register
    logic dq_oe_n_r;
    logic refresh_r;

    // ---- command decode ----
    // clock counts only in run with cke high
    wire logic clk_act;
    assign clk_act = (pwr_r == PWR_RUN) && cke;
    wire sdq_cmd_t cmd;
    assign cmd = {cs_n, ras_n, cas_n, we_n};
    // decoder enabled only with chip select low
    wire logic cmd_sel;
    assign cmd_sel = clk_act && !cs_n;
    wire logic cmd_act;
    wire logic cmd_rd;
    wire logic cmd_wr;
    wire logic cmd_pre;
    wire logic cmd_ref;
    wire logic cmd_lmr;
    wire logic cmd_bst;
    assign cmd_act = cmd_sel && (cmd == CMD_ACT);
    assign cmd_rd = cmd_sel && (cmd == CMD_RD);
    assign cmd_wr = cmd_sel && (cmd == CMD_WR);
    assign cmd_pre = cmd_sel && (cmd == CMD_PRE);
    assign cmd_ref = cmd_sel && (cmd == CMD_REF);
    assign cmd_lmr = cmd_sel && (cmd == CMD_LMR);
    assign cmd_bst = cmd_sel && (cmd == CMD_BST);
    wire logic cmd_rw;
    assign cmd_rw = cmd_rd || cmd_wr;

    // ---- address fields ----
    wire logic [ADDR_W-1:0] a;
    assign a = row_column_address_lines;
    // line ten is scope on precharge, auto precharge on access
    wire logic precharge_scope_line;
    assign precharge_scope_line = a[APRE_BIT];
    // column skips line ten
    wire logic [COL_FULL_W-1:0] col_full;
    assign col_full = {a[ADDR_W-1:APRE_BIT+1], a[APRE_BIT-1:0]};
    wire logic [COL_W-1:0] cmd_col;
    assign cmd_col = col_full[COL_W-1:0];

    // ---- burst length decode ----
    wire logic bl_full;
    assign bl_full = (bl_code_r == BL_FULL);
    wire logic [COL_W-1:0] bl_mask; // locations minus one
    assign bl_mask = bl_full ? {COL_W{1'b1}} :
                     (bl_code_r == BL_2) ? COL_W'(BL_MASK_2) :
                     (bl_code_r == BL_4) ? COL_W'(BL_MASK_4) :
                     (bl_code_r == BL_8) ? COL_W'(BL_MASK_8) :
                     '0;

    // ---- access of this edge ----
    wire logic rd_in_ready;
    // a live burst carries on unless a new access or stop comes
    wire logic acc_cont;
    assign acc_cont = clk_act && burst_r && !cmd_rw && !cmd_bst;
    wire logic acc_wr;
    assign acc_wr = cmd_rw ? cmd_wr : burst_wr_r;
    wire logic [BANK_W-1:0] acc_bank;
    assign acc_bank = cmd_rw ? bank_select_bits : bbank_r;
    wire logic [COL_W-1:0] acc_start;
    assign acc_start = cmd_rw ? cmd_col : start_r;
    wire logic [COL_W-1:0] acc_cnt;
    assign acc_cnt = cmd_rw ? '0 : cnt_r;
    // sequential or interleaved order inside the burst window
    wire logic [COL_W-1:0] acc_low;
    assign acc_low = bt_r ? (acc_start ^ acc_cnt) : COL_W'(acc_start + acc_cnt);
    wire logic [COL_W-1:0] acc_col;
    assign acc_col = (acc_start & ~bl_mask) | (acc_low & bl_mask);
    // reads wait while the buffer is full
    wire logic acc_go;
    assign acc_go = (cmd_rw || acc_cont) && (acc_wr || rd_in_ready);
    wire logic acc_last;
    assign acc_last = !bl_full && (acc_cnt == bl_mask);
    wire logic apre_fire; // self-timed row close
    assign apre_fire = acc_go && acc_last &&
                       (cmd_rw ? precharge_scope_line : burst_apre_r);
    wire logic [MI_W-1:0] mem_idx;
    assign mem_idx = {acc_bank, acc_col[MEM_CB-1:0]};

    // ---- burst state ----
    // counter moves on every active edge that makes an access
    always_ff @(posedge ref_clk or negedge resetn) begin
        if (!resetn) begin
            burst_r <= 1'b0;
            burst_wr_r <= 1'b0;
            burst_apre_r <= 1'b0;
            bbank_r <= '0;
            start_r <= '0;
            cnt_r <= '0;
        end else if (acc_go) begin
            burst_r <= !acc_last;
            cnt_r <= COL_W'(acc_cnt + 1'b1);
            if (cmd_rw) begin
                burst_wr_r <= cmd_wr;
                burst_apre_r <= precharge_scope_line;
                bbank_r <= bank_select_bits;
                start_r <= cmd_col;
            end
        end else if (cmd_bst) begin
            burst_r <= 1'b0;
        end
    end

    // ---- mode word ----
    always_ff @(posedge ref_clk or negedge resetn) begin
        if (!resetn) begin
            bl_code_r <= BL_1;
            bt_r <= 1'b0;
        end else if (cmd_lmr) begin
            bl_code_r <= a[MODE_BL_LSB +: MODE_BL_W];
            bt_r <= a[MODE_BT_BIT];
        end
    end

    // ---- per-bank row tracking ----
    genvar b;
    generate
        for (b = 0; b < BANK_CNT; b++) begin : g_bank
            wire logic hit;
            assign hit = (bank_select_bits == BANK_W'(b));
            wire logic close;
            assign close = (cmd_pre && (precharge_scope_line || hit)) ||
                           (apre_fire && (acc_bank == BANK_W'(b)));
            // banks act alone, so one closes while another bursts
            always_ff @(posedge ref_clk or negedge resetn) begin
                if (!resetn) begin
                    open_r[b] <= 1'b0;
                    row_r[b] <= '0;
                end else if (cmd_act && hit) begin
                    open_r[b] <= 1'b1;
                    row_r[b] <= a;
                end else if (close) begin
                    open_r[b] <= 1'b0;
                end
            end
        end
    endgenerate

    // ---- write path ----
    // masked words are dropped
    always_ff @(posedge ref_clk) begin
        if (acc_go && acc_wr && !dqm) begin
            mem_r[mem_idx] <= dq_in;
        end
    end

    // ---- read path ----
    sdq_stream_if #(.W(DATA_W)) rd_up ();
    sdq_stream_if #(.W(DATA_W)) rd_dn ();
    assign rd_up.data = mem_r[mem_idx];
    assign rd_up.valid = acc_go && !acc_wr;
    assign rd_in_ready = rd_up.ready;
    // drain stalls during clock suspend
    assign rd_dn.ready = clk_act;

    // holds read words across a stall
    sdq_pair_buf #(.W(DATA_W), .DEPTH(2)) i_sdq_pair_buf (
        .ref_clk(ref_clk),
        .resetn(resetn),
        .up(rd_up),
        .dn(rd_dn)
    );

    // mask delay runs every edge
    always_ff @(posedge ref_clk or negedge resetn) begin
        if (!resetn) begin
            dqm_d1_r <= 1'b0;
            dqm_d2_r <= 1'b0;
        end else begin
            dqm_d1_r <= dqm;
            dqm_d2_r <= dqm_d1_r;
        end
    end

    // two-stage output pipe, frozen while clock is off
    always_ff @(posedge ref_clk or negedge resetn) begin
        if (!resetn) begin
            pipe_r <= '0;
            pipe_vld_r <= 1'b0;
            dq_out_r <= '0;
            dq_oe_n_r <= 1'b1;
        end else if (clk_act) begin
            pipe_r <= rd_dn.data;
            pipe_vld_r <= rd_dn.valid;
            dq_out_r <= pipe_r;
            dq_oe_n_r <= !(pipe_vld_r && !dqm_d2_r);
        end
    end

    // ---- power states ----
    // cke low picks the state from burst status, bank status and a refresh command
    always_comb begin
        pwr_nxt = pwr_r;
        case (pwr_r)
            PWR_RUN: begin
                if (!cke) begin
                    if (burst_r) begin
                        pwr_nxt = PWR_SUSP;
                    end else if (|open_r) begin
                        pwr_nxt = PWR_PDN_ACT;
                    end else if (!cs_n && ({ras_n, cas_n, we_n} == CMD_REF[2:0])) begin
                        pwr_nxt = PWR_SELF;
                    end else begin
                        pwr_nxt = PWR_PDN_PRE;
                    end
                end
            end
            PWR_SUSP, PWR_PDN_PRE, PWR_PDN_ACT, PWR_SELF: begin
                if (cke) begin
                    pwr_nxt = PWR_RUN;
                end
            end
            default: begin
                pwr_nxt = PWR_RUN;
            end
        endcase
    end

    // state register and refresh strobe
    always_ff @(posedge ref_clk or negedge resetn) begin
        if (!resetn) begin
            pwr_r <= PWR_RUN;
            refresh_r <= 1'b0;
        end else begin
            pwr_r <= pwr_nxt;
            refresh_r <= cmd_ref;
        end
    end

    // ---- outputs ----
    assign dq_out = dq_out_r;
    assign dq_oe_n = dq_oe_n_r;
    assign pwr_state = pwr_r;
    assign bank_open = open_r;
    assign burst_busy = burst_r;
    assign refresh_pulse = refresh_r;
    // input buffers off in power-down and self refresh
    assign in_buf_en = (pwr_r == PWR_RUN) || (pwr_r == PWR_SUSP);

    // ---- checks ----
    a_cs_masks_cmd: assert property (@(posedge ref_clk) disable iff (!resetn)
        cs_n && !burst_r |=> $stable(open_r))
        else $error("command taken with chip select high");

    a_act_opens_row: assert property (@(posedge ref_clk) disable iff (!resetn)
        cmd_act && bank_select_bits == '0 |=> open_r[0] && row_r[0] == $past(a))
        else $error("activate did not open row");

    a_pre_all_close: assert property (@(posedge ref_clk) disable iff (!resetn)
        cmd_pre && precharge_scope_line |=> open_r == '0)
        else $error("precharge all left a bank open");

    a_pre_one_keeps: assert property (@(posedge ref_clk) disable iff (!resetn)
        cmd_pre && !precharge_scope_line && bank_select_bits == '0 && open_r[1]
        && !(apre_fire && acc_bank == BANK_W'(1)) |=> open_r[1])
        else $error("single precharge closed another bank");

    a_pdn_precharge: assert property (@(posedge ref_clk) disable iff (!resetn)
        pwr_r == PWR_RUN && !cke && !burst_r && open_r == '0 && cs_n
        |=> pwr_r == PWR_PDN_PRE)
        else $error("idle cke low did not power down");

    a_pdn_active: assert property (@(posedge ref_clk) disable iff (!resetn)
        pwr_r == PWR_RUN && !cke && !burst_r && |open_r |=> pwr_r == PWR_PDN_ACT)
        else $error("open row cke low not active power-down");

    a_suspend_hold: assert property (@(posedge ref_clk) disable iff (!resetn)
        pwr_r == PWR_SUSP [*2] |-> $stable(cnt_r) && $stable(dq_out_r))
        else $error("burst moved during clock suspend");

    a_dqm_float: assert property (@(posedge ref_clk) disable iff (!resetn)
        (clk_act && dqm) ##2 clk_act |=> dq_oe_n)
        else $error("mask did not float output after two clocks");

    a_auto_close: assert property (@(posedge ref_clk) disable iff (!resetn)
        apre_fire && !cmd_act |=> !open_r[$past(acc_bank)])
        else $error("auto precharge left row open");

    a_wake_cke: assert property (@(posedge ref_clk) disable iff (!resetn)
        pwr_r != PWR_RUN && cke |=> pwr_r == PWR_RUN)
        else $error("cke high did not exit power state");
endmodule : sdq_ctrl
`default_nettype wire

// File: sim/sdq_host_model.sv
// sdq_host_model: memory controller model driving the command and data pins
`timescale 1ns/10ps
`default_nettype none
module sdq_host_model (
    // clock
    input wire logic ref_clk,
    // command pins
    output var logic cke,
    output var logic cs_n,
    output var logic ras_n,
    output var logic cas_n,
    output var logic we_n,
    output var logic [sdq_pkg::BANK_W-1:0] bank_select_bits,
    output var logic [sdq_pkg::ADDR_W-1:0] row_column_address_lines,
    // data pins
    output var logic dqm,
    output var logic [15:0] dq_in
);
    import sdq_pkg::*;
    logic [BANK_CNT-1:0] row_open_r; // banks the controller believes open
    int misuse_cnt; // column accesses sent to a closed bank
    // idle pins at time zero, clock enable high
    initial begin
        cke = 1'b1;
        {cs_n, ras_n, cas_n, we_n} = 4'h7;
        bank_select_bits = 2'h0;
        row_column_address_lines = 13'h0;
        dqm = 1'b0;
        dq_in = 16'h0;
        row_open_r = 4'h0;
        misuse_cnt = 0;
    end
    // one command per cycle, launched at the falling edge
    task automatic issue(input sdq_cmd_t code, input logic [1:0] ba, input logic [12:0] a,
                         input logic [15:0] d, input logic m);
        @(negedge ref_clk);
        {cs_n, ras_n, cas_n, we_n} = code;
        bank_select_bits = ba;
        row_column_address_lines = a;
        dq_in = d;
        dqm = m;
        // open-row bookkeeping for selected commands only
        if (code == CMD_ACT) begin
            row_open_r[ba] = 1'b1;
        end else if (code == CMD_PRE) begin
            if (a[APRE_BIT]) row_open_r = 4'h0;
            else row_open_r[ba] = 1'b0;
        end else if (code == CMD_RD || code == CMD_WR) begin
            if (!row_open_r[ba]) misuse_cnt++;
            if (a[APRE_BIT]) row_open_r[ba] = 1'b0;
        end
    endtask : issue
    // no-operation cycles; unused lines toggle so stale values never look valid
    task automatic idle(input int n);
        repeat (n) begin
            @(negedge ref_clk);
            {cs_n, ras_n, cas_n, we_n} = 4'h7;
            bank_select_bits = ~bank_select_bits;
            row_column_address_lines = ~row_column_address_lines;
            dq_in = ~dq_in;
            dqm = 1'b0;
        end
    endtask : idle
    // clock enable change, called at a falling edge
    task automatic set_cke(input logic v);
        cke = v;
    endtask : set_cke
endmodule : sdq_host_model
`default_nettype wire

// File: sim/sdq_ctrl_bench.sv
// sdq_ctrl_bench: self-checking bench of the sdram control block
`timescale 1ns/10ps
`default_nettype none
module sdq_ctrl_bench;
    import sdq_pkg::*;
    localparam sdq_cmd_t NOP_C = 4'h7; // no operation
    localparam sdq_cmd_t DESEL_C = 4'hb; // activate pattern with chip select high
    logic ref_clk, resetn, cke, cs_n, ras_n, cas_n, we_n, dqm, dq_oe_n;
    logic burst_busy, refresh_pulse, in_buf_en;
    logic [1:0] bank_select_bits;
    logic [12:0] row_column_address_lines;
    logic [15:0] dq_in, dq_out;
    logic [3:0] bank_open;
    sdq_pwr_t pwr_state;
    logic [15:0] wd [8]; // words expected in bank 1 columns
    int num_errors = 0;
    int n_tests = 0;
    // clock and reset
    initial ref_clk = 1'b0;
    always #25 ref_clk = ~ref_clk;
    initial resetn = 1'b0;
    sdq_host_model i_sdq_host_model (.ref_clk(ref_clk), .cke(cke), .cs_n(cs_n), .ras_n(ras_n),
        .cas_n(cas_n), .we_n(we_n), .bank_select_bits(bank_select_bits),
        .row_column_address_lines(row_column_address_lines), .dqm(dqm), .dq_in(dq_in));
    sdq_ctrl i_sdq_ctrl (.ref_clk(ref_clk), .resetn(resetn), .cke(cke), .cs_n(cs_n),
        .ras_n(ras_n), .cas_n(cas_n), .we_n(we_n), .bank_select_bits(bank_select_bits),
        .row_column_address_lines(row_column_address_lines), .dqm(dqm), .dq_in(dq_in),
        .dq_out(dq_out), .dq_oe_n(dq_oe_n), .pwr_state(pwr_state), .bank_open(bank_open),
        .burst_busy(burst_busy), .refresh_pulse(refresh_pulse), .in_buf_en(in_buf_en));
    // compare a value
    task automatic chk_val(input string what, input logic [15:0] exp, input logic [15:0] got);
        n_tests++;
        if (got !== exp) begin
            num_errors++;
            $display("MISMATCH %s expected %h seen %h", what, exp, got);
        end
    endtask : chk_val
    // compare the power state
    task automatic chk_pwr(input string what, input sdq_pwr_t exp);
        n_tests++;
        if (pwr_state !== exp) begin
            num_errors++;
            $display("MISMATCH %s expected %h seen %h", what, exp, pwr_state);
        end
    endtask : chk_pwr
    task automatic cmd(input sdq_cmd_t c, input logic [1:0] ba, input logic [12:0] a,
                       input logic [15:0] d = 16'h0, input logic m = 1'b0);
        i_sdq_host_model.issue(c, ba, a, d, m);
    endtask : cmd
    task automatic nop(input int n);
        i_sdq_host_model.idle(n);
    endtask : nop
    // column order of a burst, worked out from start, length and sequence kind
    function automatic logic [15:0] exp_word(input logic [2:0] s, input int i, input int n,
                                             input logic il);
        logic [2:0] m;
        logic [2:0] c;
        m = 3'(n - 1);
        c = il ? (s ^ 3'(i)) : ((s & ~m) | ((s + 3'(i)) & m));
        return wd[c];
    endfunction : exp_word
    // four-word write to bank 1 from column 0, word number skip masked if it is below 4
    task automatic write4(input logic [15:0] base, input int skip);
        for (int i = 0; i < 4; i++) begin
            cmd((i == 0) ? CMD_WR : NOP_C, 2'h1, 13'h0, base + 16'(i), i == skip);
            if (i != skip) wd[i] = base + 16'(i);
        end
    endtask : write4
    // read burst, words looked at two cycles after the command
    task automatic read_burst(input logic [1:0] ba, input logic [12:0] a, input int n,
                              input logic il);
        cmd(CMD_RD, ba, a);
        nop(2);
        for (int i = 0; i < n; i++) begin
            nop(1);
            chk_val("read word", exp_word(a[2:0], i, n, il), dq_out);
            chk_val("read drive", 16'h0, {15'h0, dq_oe_n});
        end
        nop(1);
        chk_val("read release", 16'h1, {15'h0, dq_oe_n});
    endtask : read_burst
    task automatic t_reset();
        chk_pwr("reset state", PWR_RUN);
        chk_val("reset banks", 16'h0, {12'h0, bank_open});
        chk_val("reset flags", 16'h9, {12'h0, dq_oe_n, burst_busy, refresh_pulse, in_buf_en});
        chk_val("reset data", 16'h0, dq_out);
    endtask : t_reset
    task automatic t_banks();
        cmd(CMD_ACT, 2'h0, 13'h1fff);
        cmd(CMD_ACT, 2'h2, 13'h0001);
        cmd(DESEL_C, 2'h3, 13'h0002);
        nop(1);
        chk_val("open banks", 16'h5, {12'h0, bank_open});
        cmd(CMD_PRE, 2'h2, 13'h0);
        cmd(CMD_ACT, 2'h3, 13'h0);
        nop(1);
        chk_val("one bank closed", 16'h9, {12'h0, bank_open});
        cmd(CMD_PRE, 2'h1, 13'h0400);
        nop(1);
        chk_val("all closed", 16'h0, {12'h0, bank_open});
    endtask : t_banks
    task automatic t_burst();
        cmd(CMD_LMR, 2'h0, 13'(BL_4));
        cmd(CMD_ACT, 2'h1, 13'h0abc);
        write4(16'h5a00, 9);
        write4(16'hc300, 2);
        read_burst(2'h1, 13'h001, 4, 1'b0);
        cmd(CMD_LMR, 2'h0, 13'(BL_4) | 13'h008);
        read_burst(2'h1, 13'h001, 4, 1'b1);
        cmd(CMD_LMR, 2'h0, 13'(BL_2));
        read_burst(2'h1, 13'h003, 2, 1'b0);
        read_burst(2'h1, 13'h402, 2, 1'b0);
        chk_val("auto precharge", 16'h0, {12'h0, bank_open});
    endtask : t_burst
    task automatic t_stop();
        cmd(CMD_ACT, 2'h1, 13'h0);
        cmd(CMD_ACT, 2'h2, 13'h0);
        cmd(CMD_LMR, 2'h0, 13'(BL_8));
        cmd(CMD_RD, 2'h1, 13'h0);
        cmd(CMD_PRE, 2'h2, 13'h0);
        cmd(CMD_BST, 2'h1, 13'h0);
        chk_val("precharge in burst", 16'h2, {12'h0, bank_open});
        chk_val("burst running", 16'h1, {15'h0, burst_busy});
        nop(1);
        chk_val("burst stopped", 16'h0, {15'h0, burst_busy});
        nop(4);
    endtask : t_stop
    task automatic t_power();
        cmd(CMD_PRE, 2'h0, 13'h0400);
        cmd(CMD_REF, 2'h0, 13'h0);
        nop(1);
        chk_val("refresh pulse", 16'h1, {15'h0, refresh_pulse});
        i_sdq_host_model.set_cke(1'b0);
        nop(1);
        chk_pwr("idle power down", PWR_PDN_PRE);
        chk_val("buffers off", 16'h0, {15'h0, in_buf_en});
        cmd(CMD_ACT, 2'h0, 13'h0);
        i_sdq_host_model.set_cke(1'b1);
        nop(1);
        chk_pwr("power down exit", PWR_RUN);
        chk_val("ignored while down", 16'h0, {12'h0, bank_open});
        cmd(CMD_ACT, 2'h0, 13'h0);
        nop(1);
        i_sdq_host_model.set_cke(1'b0);
        nop(1);
        chk_pwr("active power down", PWR_PDN_ACT);
        i_sdq_host_model.set_cke(1'b1);
        cmd(CMD_PRE, 2'h0, 13'h0400);
        cmd(CMD_REF, 2'h0, 13'h0);
        i_sdq_host_model.set_cke(1'b0);
        nop(1);
        chk_pwr("self refresh", PWR_SELF);
        i_sdq_host_model.set_cke(1'b1);
        cmd(CMD_LMR, 2'h0, 13'(BL_FULL));
        cmd(CMD_ACT, 2'h0, 13'h0);
        cmd(CMD_RD, 2'h0, 13'h0);
        nop(1);
        i_sdq_host_model.set_cke(1'b0);
        nop(2);
        chk_pwr("clock suspend", PWR_SUSP);
        chk_val("buffers on", 16'h1, {15'h0, in_buf_en});
        i_sdq_host_model.set_cke(1'b1);
        nop(1);
        chk_pwr("suspend exit", PWR_RUN);
        nop(10);
        chk_val("full page running", 16'h1, {15'h0, burst_busy});
    endtask : t_power
    // verdict and end of run
    task automatic print_verdict();
        if (num_errors == 0 && n_tests > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask : print_verdict
    // watchdog, far beyond the hundred or so cycles of the tests
    initial begin
        #200000;
        num_errors++;
        print_verdict();
    end
    // main sequence
    initial begin
        repeat (16) @(posedge ref_clk);
        @(negedge ref_clk);
        resetn = 1'b1;
        t_reset();
        t_banks();
        t_burst();
        t_stop();
        t_power();
        chk_val("closed bank access", 16'h0, 16'(i_sdq_host_model.misuse_cnt));
        print_verdict();
    end
endmodule : sdq_ctrl_bench
`default_nettype wire
